/* File: verilog/csir_regs.sv */
// Purpose: Status and mask register plus soft reset and identification register
// Assumes: Byte-wide register port with one-cycle write strobe, status inputs from analog side
// Notes:   Read data is registered, one cycle after the read strobe
//          Writes are ignored while the soft reset sequence runs
//          Status bits lag their pins by two clocks
// Overview of operation
// - Bit 7 of the status register reads 1 when the input supply is attached and 0 otherwise.
// - Bit 6 reads 1 while the input voltage regulation loop is active.
// - Bit 5 reads 1 while the input current regulation loop is active.
// - Bit 3 reads 1 while the top-off timer is counting.
// - Bit 2 reads 1 while the device is in input overvoltage.
// - A voltage-loop interrupt pulse is sent on loop entry unless its mask bit is 1.
// - A current-loop interrupt pulse is sent on loop entry unless its mask bit is 1.
// - Writing 1 to the soft-reset bit restores all registers to defaults and restarts the safety timer.
// - The soft-reset bit reads 1 only during the reset sequence and then clears itself.
// - Writing 0 to the soft-reset bit changes nothing.
`timescale 1ns/1ps
`include "csir_cfg.svh"
module csir_regs
  import csir_pkg::*;
#(
  parameter logic [3:0] SRST_CYCLES = `CSIR_SRST_CYCLES,
  // Arbitrary identification values
  parameter logic [3:0] PART_CODE   = `CSIR_PART_CODE,
  parameter logic [1:0] REV_CODE    = `CSIR_REV_CODE
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // Register port
  input  wire logic [`CSIR_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // Status levels from the analog side
  input  wire logic                   input_attached,
  input  wire logic                   input_voltage_loop_active,
  input  wire logic                   input_current_loop_active,
  input  wire logic                   topoff_timer_running,
  input  wire logic                   input_overvoltage_flag,
  // Event and control outputs
  output logic                        voltage_loop_irq,
  output logic                        current_loop_irq,
  output logic                        safety_timer_restart,
  output logic                        regs_soft_reset
);
  typedef struct packed {
    // Soft reset sequencer
    csir_state_t state;
    logic [3:0]  count;
    // Writable mask bits
    logic        vmask;
    logic        imask;
    // Loop edge detection and pulses
    logic        vloop_d;
    logic        iloop_d;
    logic        virq;
    logic        iirq;
    logic        timer_rst;
    // Read data
    logic [7:0]  rdata;
  } csir_regs_t;

  csir_regs_t              r;
  csir_regs_t              next_r;
  logic [`CSIR_SYNC_W-1:0] stat_sync;
  logic                    srst_busy;
  logic                    wr_status;
  logic                    wr_srst_set;
  logic                    vloop_now;
  logic                    iloop_now;

  // Elaboration checks
  if (SRST_CYCLES == 4'h0) begin : g_bad_srst
    $error("csir_regs soft reset length must be at least one cycle");
  end
  if ($bits(PART_CODE) != `CSIR_PART_HI - `CSIR_PART_LO + 1) begin : g_bad_part
    $error("csir_regs part code does not fit its field");
  end
  if ($bits(REV_CODE) != `CSIR_REV_HI - `CSIR_REV_LO + 1) begin : g_bad_rev
    $error("csir_regs revision code does not fit its field");
  end
  if (`CSIR_SYNC_ATTACH >= `CSIR_SYNC_W) begin : g_bad_sync
    $error("csir_regs status vector too narrow");
  end

  csir_sync #(
    .WIDTH (`CSIR_SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .nrst     (nrst),
    .async_in ({input_attached, input_voltage_loop_active, input_current_loop_active,
                topoff_timer_running, input_overvoltage_flag}),
    .sync_out (stat_sync)
  );

  // Address decode shared by the read and write paths
  function automatic logic csir_is_status(input logic [`CSIR_ADDR_W-1:0] a);
    return (a == `CSIR_OFS_STATUS);
  endfunction

  function automatic logic csir_is_ident(input logic [`CSIR_ADDR_W-1:0] a);
    return (a == `CSIR_OFS_IDENT);
  endfunction

  // Loop entry seen with its mask open
  function automatic logic csir_entry(input logic now, input logic prev, input logic mask);
    return now && !prev && !mask;
  endfunction

  // Status byte; reserved bit reads 0
  function automatic logic [7:0] csir_status_byte(input logic [`CSIR_SYNC_W-1:0] s, input logic vm,
                                                  input logic im);
    logic [7:0] d;
    d                   = `CSIR_BYTE_ZERO;
    d[`CSIR_BIT_ATTACH] = s[`CSIR_SYNC_ATTACH];
    d[`CSIR_BIT_VLOOP]  = s[`CSIR_SYNC_VLOOP];
    d[`CSIR_BIT_ILOOP]  = s[`CSIR_SYNC_ILOOP];
    d[`CSIR_BIT_TOPOFF] = s[`CSIR_SYNC_TOPOFF];
    d[`CSIR_BIT_OVP]    = s[`CSIR_SYNC_OVP];
    d[`CSIR_BIT_VMASK]  = vm;
    d[`CSIR_BIT_IMASK]  = im;
    return d;
  endfunction

  // Ident byte; reserved bit reads 0
  function automatic logic [7:0] csir_ident_byte(input logic busy);
    logic [7:0] d;
    d                              = `CSIR_BYTE_ZERO;
    d[`CSIR_BIT_SRST]              = busy;
    d[`CSIR_PART_HI:`CSIR_PART_LO] = PART_CODE;
    d[`CSIR_REV_HI:`CSIR_REV_LO]   = REV_CODE;
    return d;
  endfunction

  // Unmapped addresses read 0
  function automatic logic [7:0] csir_read(input logic [`CSIR_ADDR_W-1:0] a, input logic [`CSIR_SYNC_W-1:0] s,
                                           input logic vm, input logic im, input logic busy);
    logic [7:0] d;
    d = `CSIR_BYTE_ZERO;
    if (csir_is_status(a)) begin
      d = csir_status_byte(s, vm, im);
    end else if (csir_is_ident(a)) begin
      d = csir_ident_byte(busy);
    end
    return d;
  endfunction

  assign srst_busy   = (r.state == CSIR_RESETTING);
  assign wr_status   = reg_wr && csir_is_status(reg_addr);
  assign wr_srst_set = reg_wr && csir_is_ident(reg_addr) && reg_wdata[`CSIR_BIT_SRST];
  assign vloop_now   = stat_sync[`CSIR_SYNC_VLOOP];
  assign iloop_now   = stat_sync[`CSIR_SYNC_ILOOP];

  // Next-state logic

  always_comb begin
    next_r           = r;
    // Pulses last one cycle
    next_r.virq      = 1'b0;
    next_r.iirq      = 1'b0;
    next_r.timer_rst = 1'b0;
    // Loop entry pulses
    next_r.vloop_d   = vloop_now;
    next_r.iloop_d   = iloop_now;
    if (csir_entry(vloop_now, r.vloop_d, r.vmask)) begin
      next_r.virq = 1'b1;
    end
    if (csir_entry(iloop_now, r.iloop_d, r.imask)) begin
      next_r.iirq = 1'b1;
    end

    // Read capture; data holds until the next read
    if (reg_rd) begin
      next_r.rdata = csir_read(reg_addr, stat_sync, r.vmask, r.imask, srst_busy);
    end

    // Mask writes and the soft reset sequencer
    case (r.state)
      CSIR_IDLE: begin
        if (wr_status) begin
          next_r.vmask = reg_wdata[`CSIR_BIT_VMASK];
          next_r.imask = reg_wdata[`CSIR_BIT_IMASK];
        end else if (wr_srst_set) begin
          next_r.state     = CSIR_RESETTING;
          next_r.count     = SRST_CYCLES;
          next_r.timer_rst = 1'b1;
        end
      end
      CSIR_RESETTING: begin
        // Writes are ignored until the sequence ends
        next_r.vmask = `CSIR_MASK_RESET;
        next_r.imask = `CSIR_MASK_RESET;
        next_r.count = r.count - 4'h1;
        if (r.count == 4'h1) begin
          next_r.state = CSIR_IDLE;
        end
      end
      default: begin
        next_r.state = CSIR_IDLE;
      end
    endcase
  end

  // Synchronous reset to the power-up defaults
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r       <= '0;
      r.state <= CSIR_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops, except regs_soft_reset, which is decoded from the state
  assign reg_rdata            = r.rdata;
  assign voltage_loop_irq     = r.virq;
  assign current_loop_irq     = r.iirq;
  assign safety_timer_restart = r.timer_rst;
  assign regs_soft_reset      = srst_busy;
endmodule

/* File: inc/csir_cfg.svh */
// Purpose: Constants for the charger status and identification register pair
// Assumes: Byte-wide register port, offsets as printed
// Notes:   Included by the package and the csir_regs module
`ifndef CSIR_CFG_SVH
`define CSIR_CFG_SVH
`define CSIR_ADDR_W        8
`define CSIR_OFS_STATUS    8'h0A
`define CSIR_OFS_IDENT     8'h0B
`define CSIR_BIT_ATTACH    7
`define CSIR_BIT_VLOOP     6
`define CSIR_BIT_ILOOP     5
`define CSIR_BIT_TOPOFF    3
`define CSIR_BIT_OVP       2
`define CSIR_BIT_VMASK     1
`define CSIR_BIT_IMASK     0
`define CSIR_BIT_SRST      7
`define CSIR_PART_HI       6
`define CSIR_PART_LO       3
`define CSIR_REV_HI        1
`define CSIR_REV_LO        0
`define CSIR_MASK_RESET    1'b0
`define CSIR_SRST_CYCLES   4'h4
// Identification values below are arbitrary
`define CSIR_PART_CODE     4'h5
`define CSIR_REV_CODE      2'h2
// Positions in the synchronised status vector
`define CSIR_SYNC_W        5
`define CSIR_SYNC_ATTACH   4
`define CSIR_SYNC_VLOOP    3
`define CSIR_SYNC_ILOOP    2
`define CSIR_SYNC_TOPOFF   1
`define CSIR_SYNC_OVP      0
`define CSIR_BYTE_ZERO     8'h00
`endif

/* File: inc/csir_pkg.sv */
// Purpose: Types for the charger status and identification register pair
// Assumes: csir_cfg.svh supplies the numbers
// Notes:   Holds the state enumeration; struct types live in the modules
`include "csir_cfg.svh"
package csir_pkg;
  typedef enum logic [1:0] {
    CSIR_IDLE,
    CSIR_RESETTING
  } csir_state_t;
endpackage

/* File: verilog/csir_sync.sv */
// Purpose: Two-stage synchroniser for a bus of level inputs
// Assumes: Inputs are levels from outside the mclk domain
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module csir_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } csir_sync_t;

  csir_sync_t r;
  csir_sync_t next_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("csir_sync width must be positive");
  end

  always_comb begin
    next_r        = r;
    next_r.stage1 = async_in;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stage2;
endmodule

/* File: verification/csir_regs_props.sv */
// Purpose: Port-level checker for the status and ident register pair
// Assumes: Bound to csir_regs, default SRST_CYCLES of 4
// Notes:   Sees only top-level ports
`timescale 1ns/1ps
module csir_regs_props #(
  parameter logic [3:0] SRST_CYCLES = 4'h4
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       input_voltage_loop_active,
  input wire logic       input_current_loop_active,
  input wire logic       voltage_loop_irq,
  input wire logic       current_loop_irq,
  input wire logic       safety_timer_restart,
  input wire logic       regs_soft_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_rst_wr;
    reg_wr && reg_addr == 8'h0B && reg_wdata[7];
  endsequence
  sequence s_busy_run;
    regs_soft_reset [*4] ##1 !regs_soft_reset;
  endsequence
  a_vloop_irq_cause: assert property (voltage_loop_irq |->
    $past(input_voltage_loop_active, 3) && !$past(input_voltage_loop_active, 4)) else $error("vloop irq w/o entry");
  a_iloop_irq_cause: assert property (current_loop_irq |->
    $past(input_current_loop_active, 3) && !$past(input_current_loop_active, 4)) else $error("iloop irq w/o entry");
  a_irq_one_pulse: assert property (voltage_loop_irq |=> !voltage_loop_irq)
    else $error("irq longer than a pulse");
  a_srst_start: assert property (!regs_soft_reset ##0 s_rst_wr |=> regs_soft_reset && safety_timer_restart)
    else $error("soft reset not started");
  a_restart_cause: assert property (safety_timer_restart |-> $past(reg_wr && reg_addr == 8'h0B && reg_wdata[7]))
    else $error("timer restart w/o write");
  a_srst_length: assert property ($rose(regs_soft_reset) |-> s_busy_run)
    else $error("soft reset length wrong");
  a_srst_zero_wr: assert property (!regs_soft_reset && reg_wr && reg_addr == 8'h0B && !reg_wdata[7] |=>
    !regs_soft_reset && !safety_timer_restart) else $error("zero write started reset");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h0B |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind csir_regs csir_regs_props #(.SRST_CYCLES(SRST_CYCLES)) u_props (.mclk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .input_voltage_loop_active, .input_current_loop_active, .voltage_loop_irq,
  .current_loop_irq, .safety_timer_restart, .regs_soft_reset);

/* File: verification/csir_host.sv */
// Purpose: Host-side model of the register port
// Assumes: Called at falling edges
// Notes:   Read data sampled a full cycle after the strobe
`timescale 1ns/1ps
module csir_host (
  input  wire logic       mclk,
  output logic      [7:0] reg_addr = 8'h00,
  output logic      [7:0] reg_wdata = 8'h00,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  input  wire logic [7:0] reg_rdata
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule

/* File: verification/charger_status_id_regs_test.sv */
// Purpose: Register-level tests of the status and ident pair
// Assumes: Default parameters, part 5 and revision 2
// Notes:   Status inputs change at falling edges
`timescale 1ns/1ps
module charger_status_id_regs_test;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       reg_wr, reg_rd, vi, ci, tr, sr;
  logic [4:0] sts = 5'h00;
  int         err_count = 0;
  int         n_tests = 0;
  int         vn = 0;
  int         cn = 0;
  int         tn = 0;
  int         sn = 0;
  always #20 mclk = ~mclk;
  always @(negedge mclk) begin
    vn = vn + int'(vi !== 1'b0);
    cn = cn + int'(ci !== 1'b0);
    tn = tn + int'(tr !== 1'b0);
    sn = sn + int'(sr !== 1'b0);
  end
  csir_host u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  csir_regs u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_attached(sts[4]), .input_voltage_loop_active(sts[3]),
    .input_current_loop_active(sts[2]), .topoff_timer_running(sts[1]), .input_overvoltage_flag(sts[0]),
    .voltage_loop_irq(vi), .current_loop_irq(ci), .safety_timer_restart(tr), .regs_soft_reset(sr));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      $display("unexpected at %0t: got %h want %h", $time, s, e);
      err_count++;
    end
  endtask
  task automatic wrap_up;
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    u_host.rd(8'h0A, d); chk(d, 8'h00);
    u_host.rd(8'h0B, d); chk(d, 8'h2A);
    u_host.rd(8'h0C, d); chk(d, 8'h00);
    u_host.wr(8'h0A, 8'h03);
    sts = 5'h1F;
    repeat (6) @(negedge mclk);
    u_host.rd(8'h0A, d); chk(d, 8'hEF);
    chk(8'(vn + cn), 8'h00);
    u_host.wr(8'h0B, 8'h00);
    u_host.rd(8'h0A, d); chk(d, 8'hEF);
    sts = 5'h00;
    repeat (6) @(negedge mclk);
    u_host.rd(8'h0A, d); chk(d, 8'h03);
    u_host.wr(8'h0B, 8'h80);
    @(negedge mclk);
    u_host.rd(8'h0B, d); chk(d, 8'hAA);
    repeat (6) @(negedge mclk);
    u_host.rd(8'h0B, d); chk(d, 8'h2A);
    chk(8'(tn), 8'h01);
    chk(8'(sn), 8'h04);
    u_host.rd(8'h0A, d); chk(d, 8'h00);
    sts = 5'h1F;
    repeat (6) @(negedge mclk);
    chk(8'(vn), 8'h01);
    chk(8'(cn), 8'h01);
    u_host.rd(8'h0A, d); chk(d, 8'hEC);
    wrap_up();
  end
endmodule
